// >>> logic/mhc_pkg.sv
// Purpose: Shared constants and types of the modem host control block.
// Assumes: A 125 MHz core clock; register words are 16 bits wide.
// Notes:   Addresses are 6-bit indices carried in the SPI command byte.

package mhc_pkg;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int STARTUP_MS = 10;
  localparam int STARTUP_CYCLES = STARTUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam longint CLK_FREQ_MILLIHZ = 64'd1000000000000 / CLK_PERIOD_NS;
  localparam longint CLKOUT_FREQ_MILLIHZ = 64'd32768000;
  localparam int CLKOUT_HALF_CYCLES =
    int'(CLK_FREQ_MILLIHZ / (2 * CLKOUT_FREQ_MILLIHZ));
  localparam int OP_CYCLES = 64;
  localparam int START_CNT_W = 21;
  localparam int HALF_CNT_W = 11;
  localparam int OP_CNT_W = 6;

  // ------------------------------------------------------------------
  // SPI framing
  // ------------------------------------------------------------------
  localparam int CMD_BITS = 8;
  localparam int DATA_BITS = 16;
  localparam logic [4:0] CMD_LAST_BIT = 5'h07;
  localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
  localparam logic [4:0] FRAME_DONE = 5'h18;
  localparam int CMD_READ_POS = 7;

  // ------------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------------
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_GPIO_CFG = 6'h01;
  localparam logic [5:0] ADDR_GPIO_DATA = 6'h02;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h03;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h04;
  localparam logic [5:0] ADDR_OP = 6'h05;
  localparam logic [5:0] ADDR_STATE = 6'h06;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int CTRL_PULLUP_POS = 0;
  localparam int CTRL_DRIVE_LSB = 1;
  localparam int CTRL_ACT_POS = 3;
  localparam int CTRL_FCS_POS = 4;
  localparam int GPIO_DIR1_POS = 0;
  localparam int GPIO_DIR2_POS = 1;
  localparam int GPIO_VAL1_POS = 8;
  localparam int GPIO_VAL2_POS = 9;
  localparam int IRQ_WAKE_ATTENTION_N_POS = 0;
  localparam int IRQ_DONE_POS = 1;
  localparam int OP_SLEEP_POS = 2;
  localparam logic [15:0] CTRL_RESET = 16'h0001;
  localparam logic [15:0] GPIO_CFG_RESET = 16'h0000;
  localparam logic [15:0] IRQ_MASK_RESET = 16'h0001;
  localparam logic [15:0] IRQ_STATUS_RESET = 16'h0000;
  localparam logic [15:0] OP_RESET = 16'h0000;

  // ------------------------------------------------------------------
  // Operation codes and states
  // ------------------------------------------------------------------
  localparam logic [1:0] OP_NONE = 2'h0;
  localparam logic [1:0] OP_RX = 2'h1;
  localparam logic [1:0] OP_TX = 2'h2;
  localparam logic [1:0] OP_CCA = 2'h3;

  typedef enum logic [1:0] {
    MHC_INIT,
    MHC_IDLE,
    MHC_BUSY,
    MHC_SLEEP
  } mhc_state_e;

endpackage

// >>> logic/mhc_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous inputs.
// Assumes: Each bit is an independent level.
// Notes:   Only the second stage leaves this module.

`timescale 1ns/1ns

module mhc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [WIDTH-1:0] async_in,
  input wire logic [WIDTH-1:0] reset_val_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic primed_reg;

  // The reset value is applied by a clocked load, not by the reset itself.
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      primed_reg <= 1'b0;
    end else begin
      primed_reg <= 1'b1;
      stage1_reg <= async_in;
      stage2_reg <= primed_reg ? stage1_reg : reset_val_in;
    end
  end

  assign sync_out = stage2_reg;

endmodule // mhc_sync

// >>> logic/mhc_host_ctrl.sv
// Purpose: Host-facing control of the radio modem: SPI slave registers,
//          power-up sequence, interrupt request and status pins.
// Assumes: SPI mode 0, 24-bit frames; serial clock well below core clock.
// Notes:   Frame is a command byte (read flag, 6-bit index) then 16 data.
//
// Contract
// - Modem is SPI slave only, host masters.
// - SPI frames read and write modem registers.
// - Hard reset is asynchronous and active low.
// - In reset, everything powered down, no clocks.
// - After release, reach idle, interrupt, clock out.
// - Leaving reset sets attention status and mask.
// - Interrupt output open drain, low while pending.
// - Reading interrupt status releases interrupt output.
// - Interrupt pull-up default on; drive strength programmable.
// - Low wake input leaves sleep modes.
// - Radio enable input gates RX, TX, CCA start.
// - GPIO1 optionally shows radio activity.
// - GPIO2 optionally shows frame check passed.
// - After reset GPIO pins are inputs, undriven.

`timescale 1ns/1ns

module mhc_host_ctrl #(
  parameter int STARTUP_CYCLES_P = mhc_pkg::STARTUP_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic serial_clock_in,
  input wire logic spi_mosi_in,
  input wire logic spi_ce_b_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_out,
  input wire logic wake_attention_b_in,
  input wire logic radio_operation_enable_in,
  output logic irq_b_out,
  output logic irq_oe_out,
  output logic irq_pullup_en_out,
  output logic [1:0] irq_drive_out,
  output logic clock_output_pin_out,
  input wire logic activity_indicator_in,
  output logic activity_indicator_out,
  output logic activity_indicator_oe_out,
  input wire logic frame_check_ok_indicator_in,
  output logic frame_check_ok_indicator_out,
  output logic frame_check_ok_indicator_oe_out
);
  import mhc_pkg::*;

  // ------------------------------------------------------------------
  // Input synchronisation
  // ------------------------------------------------------------------
  logic [6:0] sync_s;
  logic sclk_s, mosi_s, ce_b_s, wake_b_s, radio_en_s, gpio1_s, gpio2_s;

  mhc_sync #(.WIDTH(7)) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .async_in({serial_clock_in, spi_mosi_in, spi_ce_b_in,
               wake_attention_b_in, radio_operation_enable_in,
               activity_indicator_in, frame_check_ok_indicator_in}),
    .reset_val_in(7'h34),
    .sync_out(sync_s)
  );
  assign {sclk_s, mosi_s, ce_b_s, wake_b_s, radio_en_s, gpio1_s,
          gpio2_s} = sync_s;

  // ------------------------------------------------------------------
  // State and registers
  // ------------------------------------------------------------------
  mhc_state_e state_reg;
  logic [START_CNT_W-1:0] start_cnt_reg;
  logic [OP_CNT_W-1:0] op_cnt_reg;
  logic [HALF_CNT_W-1:0] half_cnt_reg;
  logic clk_out_reg;
  logic [15:0] ctrl_reg, gpio_cfg_reg, mask_reg, status_reg, op_reg;
  logic [1:0] run_op_reg;
  logic frame_ok_reg;
  logic irq_oe_reg;
  logic sclk_d_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] cmd_reg;
  logic [15:0] rx_reg, tx_reg;
  logic miso_reg;
  logic g1_out_reg, g1_oe_reg, g2_out_reg, g2_oe_reg;

  // ------------------------------------------------------------------
  // SPI decode
  // ------------------------------------------------------------------
  wire spi_active = !ce_b_s && (state_reg != MHC_INIT);
  wire sclk_rise = spi_active && sclk_s && !sclk_d_reg;
  wire sclk_fall = spi_active && !sclk_s && sclk_d_reg;
  wire [7:0] cmd_full = {cmd_reg[6:0], mosi_s};
  wire [5:0] frame_addr = cmd_reg[5:0];
  wire rd_load = sclk_rise && (bit_cnt_reg == CMD_LAST_BIT)
                 && cmd_full[CMD_READ_POS];
  wire [5:0] rd_addr = cmd_full[5:0];
  wire wr_en = sclk_rise && (bit_cnt_reg == FRAME_LAST_BIT)
               && !cmd_reg[CMD_READ_POS];
  wire [15:0] wr_data = {rx_reg[14:0], mosi_s};
  wire status_rd_clr = rd_load && (rd_addr == ADDR_IRQ_STATUS);
  wire [15:0] gpio_data = {14'h0000, gpio2_s, gpio1_s};
  wire [15:0] state_word = {14'h0000, state_reg};
  wire [15:0] rd_data =
    (rd_addr == ADDR_CTRL) ? ctrl_reg :
    (rd_addr == ADDR_GPIO_CFG) ? gpio_cfg_reg :
    (rd_addr == ADDR_GPIO_DATA) ? gpio_data :
    (rd_addr == ADDR_IRQ_MASK) ? mask_reg :
    (rd_addr == ADDR_IRQ_STATUS) ? status_reg :
    (rd_addr == ADDR_OP) ? op_reg :
    (rd_addr == ADDR_STATE) ? state_word : 16'h0000;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sclk_d_reg <= 1'b0;
      bit_cnt_reg <= 5'h00;
      cmd_reg <= 8'h00;
      rx_reg <= 16'h0000;
    end else begin
      sclk_d_reg <= sclk_s;
      if (!spi_active) begin
        bit_cnt_reg <= 5'h00;
      end else if (sclk_rise && bit_cnt_reg != FRAME_DONE) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        if (bit_cnt_reg <= CMD_LAST_BIT) begin
          cmd_reg <= cmd_full;
        end else begin
          rx_reg <= wr_data;
        end
      end
    end
  end

  // Read data leaves MSB first, changing on falling serial clock edges.
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_reg <= 16'h0000;
      miso_reg <= 1'b0;
    end else if (rd_load) begin
      tx_reg <= rd_data;
    end else if (sclk_fall && bit_cnt_reg > CMD_LAST_BIT) begin
      miso_reg <= tx_reg[15];
      tx_reg <= {tx_reg[14:0], 1'b0};
    end
  end

  assign spi_miso_out = miso_reg;
  assign spi_miso_oe_out = spi_active;

  // ------------------------------------------------------------------
  // Power-up and operating states
  // ------------------------------------------------------------------
  wire init_done = (state_reg == MHC_INIT)
                   && (start_cnt_reg == START_CNT_W'(STARTUP_CYCLES_P - 1));
  wire op_done = (state_reg == MHC_BUSY)
                 && (op_cnt_reg == OP_CNT_W'(OP_CYCLES - 1));
  wire woken = (state_reg == MHC_SLEEP) && !wake_b_s;
  wire op_start = (state_reg == MHC_IDLE) && !op_reg[OP_SLEEP_POS]
                  && (op_reg[1:0] != OP_NONE) && radio_en_s;
  wire sleep_start = (state_reg == MHC_IDLE) && op_reg[OP_SLEEP_POS];

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= MHC_INIT;
      start_cnt_reg <= '0;
      op_cnt_reg <= '0;
      run_op_reg <= OP_NONE;
      frame_ok_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        MHC_INIT: begin
          start_cnt_reg <= start_cnt_reg + START_CNT_W'(1);
          if (init_done) begin
            state_reg <= MHC_IDLE;
          end
        end
        MHC_IDLE: begin
          op_cnt_reg <= '0;
          if (sleep_start) begin
            state_reg <= MHC_SLEEP;
          end else if (op_start) begin
            state_reg <= MHC_BUSY;
            run_op_reg <= op_reg[1:0];
            frame_ok_reg <= 1'b0;
          end
        end
        MHC_BUSY: begin
          op_cnt_reg <= op_cnt_reg + OP_CNT_W'(1);
          if (op_done) begin
            state_reg <= MHC_IDLE;
            frame_ok_reg <= (run_op_reg == OP_RX);
          end
        end
        MHC_SLEEP: begin
          if (woken) begin
            state_reg <= MHC_IDLE;
          end
        end
      endcase
    end
  end

  // Clock output starts only once idle is reached.
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      half_cnt_reg <= '0;
      clk_out_reg <= 1'b0;
    end else if (state_reg != MHC_INIT) begin
      if (half_cnt_reg == HALF_CNT_W'(CLKOUT_HALF_CYCLES - 1)) begin
        half_cnt_reg <= '0;
        clk_out_reg <= !clk_out_reg;
      end else begin
        half_cnt_reg <= half_cnt_reg + HALF_CNT_W'(1);
      end
    end
  end

  assign clock_output_pin_out = clk_out_reg;

  // ------------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------------
  wire [15:0] status_set = {14'h0000, op_done,
                            init_done || woken};
  wire [15:0] status_next =
    (status_rd_clr ? 16'h0000 : status_reg) | status_set;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg <= CTRL_RESET;
      gpio_cfg_reg <= GPIO_CFG_RESET;
      mask_reg <= IRQ_MASK_RESET;
      status_reg <= IRQ_STATUS_RESET;
      op_reg <= OP_RESET;
    end else begin
      status_reg <= status_next;
      if (wr_en && frame_addr == ADDR_CTRL) begin
        ctrl_reg <= wr_data;
      end
      if (wr_en && frame_addr == ADDR_GPIO_CFG) begin
        gpio_cfg_reg <= wr_data;
      end
      if (wr_en && frame_addr == ADDR_IRQ_MASK) begin
        mask_reg <= wr_data;
      end
      if (wr_en && frame_addr == ADDR_OP) begin
        op_reg <= wr_data;
      end else if (op_start) begin
        op_reg[1:0] <= OP_NONE;
      end else if (woken) begin
        op_reg[OP_SLEEP_POS] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Interrupt request and status pins
  // ------------------------------------------------------------------
  wire act_en = ctrl_reg[CTRL_ACT_POS];
  wire fcs_en = ctrl_reg[CTRL_FCS_POS];

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_oe_reg <= 1'b0;
      g1_out_reg <= 1'b0;
      g1_oe_reg <= 1'b0;
      g2_out_reg <= 1'b0;
      g2_oe_reg <= 1'b0;
    end else begin
      irq_oe_reg <= |(status_reg & mask_reg);
      g1_oe_reg <= act_en || gpio_cfg_reg[GPIO_DIR1_POS];
      g1_out_reg <= act_en ? (state_reg == MHC_BUSY)
                           : gpio_cfg_reg[GPIO_VAL1_POS];
      g2_oe_reg <= fcs_en || gpio_cfg_reg[GPIO_DIR2_POS];
      g2_out_reg <= fcs_en ? frame_ok_reg
                           : gpio_cfg_reg[GPIO_VAL2_POS];
    end
  end

  assign irq_b_out = 1'b0;
  assign irq_oe_out = irq_oe_reg;
  assign irq_pullup_en_out = ctrl_reg[CTRL_PULLUP_POS];
  assign irq_drive_out = ctrl_reg[CTRL_DRIVE_LSB +: 2];
  assign activity_indicator_out = g1_out_reg;
  assign activity_indicator_oe_out = g1_oe_reg;
  assign frame_check_ok_indicator_out = g2_out_reg;
  assign frame_check_ok_indicator_oe_out = g2_oe_reg;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_miso_only_selected;
    ce_b_s |-> !spi_miso_oe_out;
  endproperty
  a_miso_only_selected: assert property (p_miso_only_selected)
    else $error("MISO driven while deselected");

  property p_mask_write;
    wr_en && frame_addr == ADDR_IRQ_MASK |=> mask_reg == $past(wr_data);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("Mask write lost");

  property p_init_quiet;
    state_reg == MHC_INIT |-> !clock_output_pin_out && !irq_oe_out;
  endproperty
  a_init_quiet: assert property (p_init_quiet)
    else $error("Activity during power-up");

  property p_startup_idle;
    init_done |=> state_reg == MHC_IDLE && status_reg[IRQ_WAKE_ATTENTION_N_POS];
  endproperty
  a_startup_idle: assert property (p_startup_idle)
    else $error("Idle not reached after start-up");

  property p_first_irq;
    init_done |-> ##2 irq_oe_out;
  endproperty
  a_first_irq: assert property (p_first_irq)
    else $error("No interrupt after start-up");

  property p_irq_follows;
    |(status_reg & mask_reg) |=> irq_oe_out && !irq_b_out;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("Pending interrupt not signalled");

  property p_read_clear;
    status_rd_clr && !(init_done || woken || op_done)
      |=> status_reg == 16'h0000 ##1 !irq_oe_out;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("Status read did not release interrupt");

  property p_pullup_stable;
    !(wr_en && frame_addr == ADDR_CTRL) |=> $stable(irq_pullup_en_out);
  endproperty
  a_pullup_stable: assert property (p_pullup_stable)
    else $error("Pull-up changed without a write");

  property p_wake;
    woken |=> state_reg == MHC_IDLE && status_reg[IRQ_WAKE_ATTENTION_N_POS];
  endproperty
  a_wake: assert property (p_wake)
    else $error("Wake did not leave sleep");

  property p_radio_gate;
    state_reg == MHC_IDLE && !radio_en_s |=> state_reg != MHC_BUSY;
  endproperty
  a_radio_gate: assert property (p_radio_gate)
    else $error("Operation started without enable");

  property p_activity;
    act_en && state_reg == MHC_BUSY |=>
      activity_indicator_oe_out && activity_indicator_out;
  endproperty
  a_activity: assert property (p_activity)
    else $error("Activity indicator missing");

  property p_frame_ok;
    op_done && run_op_reg == OP_RX && fcs_en ##1 fcs_en
      |=> frame_check_ok_indicator_out;
  endproperty
  a_frame_ok: assert property (p_frame_ok)
    else $error("Frame check indicator missing");

  c_idle: cover property (init_done);
  c_busy: cover property (op_start);
  c_wake: cover property (woken);
  c_read_clear: cover property (status_rd_clr && irq_oe_out);

endmodule // mhc_host_ctrl

// >>> verification/mhc_host_model.sv
// Purpose: Host model acting as SPI master and interrupt watcher.
// Assumes: Mode 0 frames of 24 bits, serial clock period 125 ns.
// Notes:   Released lines show the inverse of their last value.

`timescale 1ns/1ns

module mhc_host_model (
  input wire logic ref_clk_in,
  input wire logic irq_line_b_in,
  input wire logic miso_line_in,
  output logic sclk_out,
  output logic mosi_out,
  output logic ce_b_out,
  output logic irq_seen_out
);
  logic [1:0] irq_sync_reg;

  initial begin
    sclk_out = 1'h0;
    mosi_out = 1'h0;
    ce_b_out = 1'h1;
    irq_sync_reg = 2'h0;
  end

  // ----------------------------------------
  // Interrupt watcher
  // ----------------------------------------
  // Two flops bring the open-drain line into the host clock domain.
  always @(posedge ref_clk_in) begin
    irq_sync_reg <= {irq_sync_reg[0], ~irq_line_b_in};
  end
  assign irq_seen_out = irq_sync_reg[1];

  // ----------------------------------------
  // SPI master
  // ----------------------------------------
  // The serial clock stands low outside frames.
  task automatic frame(input logic [7:0] cmd, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd};
    rd = 16'h0000;
    ce_b_out <= 1'h0;
    mosi_out <= sh[23];
    #63;
    for (int i = 0; i < 24; i++) begin
      sclk_out <= 1'h1;
      if (i >= 8) rd = {rd[14:0], miso_line_in};
      #62;
      sclk_out <= 1'h0;
      if (i < 23) mosi_out <= sh[22-i];
      #63;
    end
    ce_b_out <= 1'h1;
    mosi_out <= ~sh[0];
    #40;
  endtask
endmodule // mhc_host_model

// >>> verification/testbench.sv
// Purpose: Self-checking bench of the modem host control block.
// Assumes: Startup shortened to 200 cycles through the parameter.
// Notes:   Random register data and pin levels from a fixed seed.

`timescale 1ns/1ns

module testbench;
  import mhc_pkg::*;
  localparam int SU = 200;
  localparam int LIMIT = 60000;
  logic ref_clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic wake_b = 1'h1;
  logic rxen = 1'h0;
  logic gp1 = 1'h0;
  logic gp2 = 1'h0;
  logic miso_last = 1'h0;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  logic sclk, mosi, ce_b, miso, miso_oe, irq_b, irq_oe, pu, clock_output_pin, seen;
  logic a_out, a_oe, f_out, f_oe;
  logic [1:0] drv;
  logic [15:0] d, r;
  wire logic miso_line = miso_oe ? miso : ~miso_last;
  wire logic irq_line_b = irq_oe ? irq_b : 1'h1;
  wire logic a_line = a_oe ? a_out : gp1;
  wire logic f_line = f_oe ? f_out : gp2;

  always #4 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) if (miso_oe) miso_last <= miso;

  mhc_host_ctrl #(.STARTUP_CYCLES_P(SU)) mhc_host_ctrl_i (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
    .serial_clock_in(sclk), .spi_mosi_in(mosi), .spi_ce_b_in(ce_b),
    .spi_miso_out(miso), .spi_miso_oe_out(miso_oe),
    .wake_attention_b_in(wake_b), .radio_operation_enable_in(rxen),
    .irq_b_out(irq_b), .irq_oe_out(irq_oe), .irq_pullup_en_out(pu),
    .irq_drive_out(drv), .clock_output_pin_out(clock_output_pin),
    .activity_indicator_in(a_line), .activity_indicator_out(a_out),
    .activity_indicator_oe_out(a_oe),
    .frame_check_ok_indicator_in(f_line),
    .frame_check_ok_indicator_out(f_out),
    .frame_check_ok_indicator_oe_out(f_oe));

  mhc_host_model mhc_host_model_i (
    .ref_clk_in(ref_clk_in), .irq_line_b_in(irq_line_b),
    .miso_line_in(miso_line), .sclk_out(sclk), .mosi_out(mosi),
    .ce_b_out(ce_b), .irq_seen_out(seen));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic stop_test();
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    mhc_host_model_i.frame({2'h2, a}, 16'h0000, v);
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    logic [15:0] x;
    mhc_host_model_i.frame({2'h0, a}, v, x);
    repeat (4) @(posedge ref_clk_in);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return irq_oe;
      1: return clock_output_pin;
      2: return a_out;
      default: return seen;
    endcase
  endfunction

  task automatic wait_lvl(input int s, input logic v, input int lim,
                          output int n);
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge ref_clk_in);
      n++;
    end
  endtask

  function automatic logic fok(input logic [1:0] op);
    return op == OP_RX;
  endfunction

  function automatic logic [15:0] pins();
    return {8'h00, irq_oe, clock_output_pin, miso_oe, a_oe, f_oe, pu, drv};
  endfunction

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int n;
    logic [1:0] op;
    void'($urandom(15));
    repeat (3) @(posedge ref_clk_in);
    chk("reset pins", 16'h0004, pins());
    rst_b_in <= 1'h1;
    wait_lvl(0, 1'h1, SU + 20, n);
    chk("startup", 1'h1, n >= SU - 1 && n <= SU + 6);
    wait_lvl(1, 1'h1, 2 * CLKOUT_HALF_CYCLES + 10, n);
    wait_lvl(1, 1'h0, CLKOUT_HALF_CYCLES + 10, n);
    chk("clock out", 1'h1, n >= CLKOUT_HALF_CYCLES - 1 &&
        n <= CLKOUT_HALF_CYCLES + 1);
    wait_lvl(3, 1'h1, 50, n);
    chk("host irq seen", 1'h1, seen);
    rd(ADDR_IRQ_STATUS, r);
    chk("wake_attention_n status", 16'h0001, r & 16'h0003);
    chk("irq released", 1'h0, irq_oe);
    rd(ADDR_IRQ_MASK, r);
    chk("irq mask", IRQ_MASK_RESET, r);
    rd(ADDR_IRQ_STATUS, r);
    chk("status cleared", 16'h0000, r);
    rd(ADDR_CTRL, r);
    chk("ctrl reset", CTRL_RESET, r);
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 16'h0007 : 16'($urandom) & 16'h001F;
      wr(ADDR_CTRL, d);
      chk("pullup pin", d[0], pu);
      chk("drive pins", d[2:1], drv);
      rd(ADDR_CTRL, r);
      chk("ctrl readback", d, r);
    end
    wr(6'h3F, 16'($urandom));
    rd(6'h3F, r);
    chk("unmapped", 16'h0000, r);
    wr(ADDR_CTRL, CTRL_RESET);
    for (int i = 0; i < 3; i++) begin
      gp1 <= 1'($urandom);
      gp2 <= 1'($urandom);
      wr(ADDR_GPIO_CFG, 16'h0000);
      rd(ADDR_GPIO_DATA, r);
      chk("gpio in", {14'h0, gp2, gp1}, r & 16'h0003);
      d = 16'($urandom) & 16'h0300 | 16'h0003;
      wr(ADDR_GPIO_CFG, d);
      chk("gpio out", {12'h0, 2'h3, d[8], d[9]},
          {12'h0, a_oe, f_oe, a_out, f_out});
    end
    wr(ADDR_GPIO_CFG, 16'h0000);
    wr(ADDR_CTRL, 16'h0019);
    wr(ADDR_IRQ_MASK, 16'h0003);
    for (int k = 1; k < 4; k++) begin
      op = 2'(k);
      wr(ADDR_OP, {14'h0, op});
      repeat (80) @(posedge ref_clk_in);
      chk("gated start", 1'h0, a_out);
      rd(ADDR_OP, r);
      chk("op held", {14'h0, op}, r);
      @(posedge ref_clk_in);
      rxen <= 1'h1;
      wait_lvl(2, 1'h1, 20, n);
      wait_lvl(2, 1'h0, OP_CYCLES + 20, n);
      chk("busy length", 1'h1, n >= OP_CYCLES - 1 &&
          n <= OP_CYCLES + 1);
      rxen <= 1'h0;
      wait_lvl(0, 1'h1, 10, n);
      chk("op irq", 1'h1, irq_oe);
      rd(ADDR_IRQ_STATUS, r);
      chk("done status", 16'h0002, r & 16'h0003);
      chk("frame ok pin", fok(op), f_out);
    end
    wr(ADDR_OP, 16'h0004);
    rd(ADDR_STATE, r);
    chk("sleep state", 16'h0003, r & 16'h0003);
    @(posedge ref_clk_in);
    wake_b <= 1'h0;
    repeat (6) @(posedge ref_clk_in);
    wake_b <= 1'h1;
    wait_lvl(0, 1'h1, 10, n);
    chk("wake irq", 1'h1, irq_oe);
    rd(ADDR_IRQ_STATUS, r);
    chk("wake wake_attention_n", 16'h0001, r & 16'h0003);
    rd(ADDR_STATE, r);
    chk("idle state", 16'h0001, r & 16'h0003);
    wr(ADDR_CTRL, 16'h0006);
    wr(ADDR_GPIO_CFG, 16'h0003);
    rst_b_in <= 1'h0;
    repeat (2) @(posedge ref_clk_in);
    chk("reset again", 16'h0004, pins());
    rst_b_in <= 1'h1;
    wait_lvl(0, 1'h1, SU + 20, n);
    chk("restart", 1'h1, n >= SU - 1 && n <= SU + 6);
    stop_test();
  end
endmodule // testbench
